//--- rtl/pfpc_top.sv
// Feedback divider configuration and divider counters of the clock PLL
// Assumes register requests arrive from serial port logic on REF_CLK_I
`timescale 1ns/1ps
`default_nettype none
`include "pfpc_regs.svh"
module pfpc_top (
	input  wire logic                 REF_CLK_I,
	input  wire logic                 RESET_I,
	input  wire pfpc_pkg::pfpc_req_t  REQ_I,
	output logic [7:0]                REG_RDATA_O,
	output logic                      PRESCALE_O,
	output logic                      FB_DIV_O,
	output logic                      STATUS_O,
	output logic                      CFG_ERR_O
);
	import pfpc_pkg::*;

	pfpc_cfg_t   cfg_reg, cfg_next;
	logic [7:0]  rdata_reg, rdata_next;
	logic [5:0]  pre_cnt_reg, pre_cnt_next;
	logic [12:0] b_cnt_reg, b_cnt_next;
	logic [5:0]  a_cnt_reg, a_cnt_next;
	logic        pre_reg, pre_next;
	logic        ndiv_reg, ndiv_next;
	logic        adiv_reg, adiv_next;
	logic        stat_reg, stat_next;
	logic        err_reg, err_next;
	logic [2:0]  code;
	logic        dm;
	logic        hold;
	logic [12:0] b_eff;

	function automatic logic [5:0] low_ratio(input logic [2:0] c);
		unique case (c)
			`PFPC_PRE_FD1:  low_ratio = 6'h01;
			`PFPC_PRE_FD2:  low_ratio = 6'h02;
			`PFPC_PRE_DM2:  low_ratio = 6'h02;
			`PFPC_PRE_DM4:  low_ratio = 6'h04;
			`PFPC_PRE_DM8:  low_ratio = 6'h08;
			`PFPC_PRE_DM16: low_ratio = 6'h10;
			`PFPC_PRE_DM32: low_ratio = 6'h20;
			`PFPC_PRE_FD3:  low_ratio = 6'h03;
		endcase
	endfunction

	function automatic logic is_dm(input logic [2:0] c);
		is_dm = !(c == `PFPC_PRE_FD1 || c == `PFPC_PRE_FD2 ||
			c == `PFPC_PRE_FD3);
	endfunction

	// Reload value of the prescaler count: ratio minus one
	function automatic logic [5:0] pre_load(input logic [2:0] c,
		input logic [5:0] a);
		logic [5:0] m;
		m = low_ratio(c);
		if (is_dm(c) && a != 6'h00) begin
			m = m + 6'h01;
		end
		pre_load = m - 6'h01;
	endfunction

	assign code = cfg_reg.ctl[2:0];
	assign dm   = is_dm(code);
	assign hold = cfg_reg.ctl[`PFPC_CTL_RST_ALL] ||
		cfg_reg.ctl[`PFPC_CTL_RST_AB];

	// Coarse count, forced to one by the bypass in fixed divide
	always_comb begin
		b_eff = (cfg_reg.coarse == 13'h0000) ? 13'h0001 : cfg_reg.coarse;
		if (cfg_reg.ctl[`PFPC_CTL_BYPASS] && !dm) begin
			b_eff = 13'h0001;
		end
	end

	// Register file
	always_comb begin
		cfg_next   = cfg_reg;
		rdata_next = 8'h00;
		if (REQ_I.wr) begin
			unique case (REQ_I.addr)
				`PFPC_OFS_SWALLOW: cfg_next.swallow = REQ_I.wdata[5:0];
				`PFPC_OFS_COARSE0: cfg_next.coarse[7:0] = REQ_I.wdata;
				`PFPC_OFS_COARSE1: cfg_next.coarse[12:8] = REQ_I.wdata[4:0];
				`PFPC_OFS_CTL:     cfg_next.ctl = REQ_I.wdata;
				`PFPC_OFS_SEL: begin
					if (!cfg_reg.gate[`PFPC_GATE_BIT]) begin
						cfg_next.sel = REQ_I.wdata;
					end
				end
				`PFPC_OFS_GATE:    cfg_next.gate = REQ_I.wdata;
				default: ;
			endcase
		end
		if (REQ_I.rd) begin
			unique case (REQ_I.addr)
				`PFPC_OFS_SWALLOW: rdata_next = {2'h0, cfg_reg.swallow};
				`PFPC_OFS_COARSE0: rdata_next = cfg_reg.coarse[7:0];
				`PFPC_OFS_COARSE1: rdata_next = {3'h0, cfg_reg.coarse[12:8]};
				`PFPC_OFS_CTL:     rdata_next = cfg_reg.ctl;
				`PFPC_OFS_SEL:     rdata_next = cfg_reg.sel;
				`PFPC_OFS_GATE:    rdata_next = cfg_reg.gate;
				default:           rdata_next = 8'h00;
			endcase
		end
	end

	// Prescaler, swallow and coarse counters
	always_comb begin
		a_cnt_next = a_cnt_reg;
		b_cnt_next = b_cnt_reg;
		pre_cnt_next = pre_cnt_reg;
		pre_next = 1'b0;
		ndiv_next = 1'b0;
		adiv_next = 1'b0;
		if (hold) begin
			a_cnt_next = cfg_reg.swallow;
			b_cnt_next = b_eff;
			pre_cnt_next = pre_load(code, cfg_reg.swallow);
		end else if (pre_cnt_reg == 6'h00) begin
			pre_next = 1'b1;
			if (b_cnt_reg <= 13'h0001) begin
				ndiv_next = 1'b1;
				a_cnt_next = cfg_reg.swallow;
				b_cnt_next = b_eff;
			end else begin
				b_cnt_next = b_cnt_reg - 13'h0001;
				if (a_cnt_reg != 6'h00) begin
					a_cnt_next = a_cnt_reg - 6'h01;
					adiv_next = (a_cnt_reg == 6'h01);
				end
			end
			pre_cnt_next = pre_load(code, a_cnt_next);
		end else begin
			pre_cnt_next = pre_cnt_reg - 6'h01;
		end
		unique case (cfg_reg.sel[7:2])
			`PFPC_SEL_NDIV: stat_next = ndiv_next;
			`PFPC_SEL_ADIV: stat_next = adiv_next;
			`PFPC_SEL_PRE:  stat_next = pre_next;
			default:        stat_next = 1'b0;
		endcase
		err_next = dm && ({7'h00, cfg_reg.swallow} > b_eff);
	end

	always_ff @(posedge REF_CLK_I) begin
		if (RESET_I) begin
			cfg_reg     <= '{swallow: `PFPC_RST_SWALLOW,
				coarse: `PFPC_RST_COARSE, ctl: `PFPC_RST_CTL,
				sel: `PFPC_RST_SEL, gate: `PFPC_RST_GATE};
			rdata_reg   <= 8'h00;
			pre_cnt_reg <= 6'h00;
			b_cnt_reg   <= 13'h0001;
			a_cnt_reg   <= 6'h00;
			pre_reg     <= 1'b0;
			ndiv_reg    <= 1'b0;
			adiv_reg    <= 1'b0;
			stat_reg    <= 1'b0;
			err_reg     <= 1'b0;
		end else begin
			cfg_reg     <= cfg_next;
			rdata_reg   <= rdata_next;
			pre_cnt_reg <= pre_cnt_next;
			b_cnt_reg   <= b_cnt_next;
			a_cnt_reg   <= a_cnt_next;
			pre_reg     <= pre_next;
			ndiv_reg    <= ndiv_next;
			adiv_reg    <= adiv_next;
			stat_reg    <= stat_next;
			err_reg     <= err_next;
		end
	end

	assign REG_RDATA_O = rdata_reg;
	assign PRESCALE_O  = pre_reg;
	assign FB_DIV_O    = ndiv_reg;
	assign STATUS_O    = stat_reg;
	assign CFG_ERR_O   = err_reg;

	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RESET_I);

	sequence s_sel_write;
		REQ_I.wr && REQ_I.addr == `PFPC_OFS_SEL;
	endsequence

	sequence s_pre_tick;
		!hold && pre_cnt_reg == 6'h00;
	endsequence

	sequence s_reload;
		s_pre_tick ##0 b_cnt_reg <= 13'h0001;
	endsequence

	a_reset_code: assert property (@(posedge REF_CLK_I)
		disable iff (1'b0) RESET_I |=> cfg_reg.ctl == `PFPC_RST_CTL)
		else $error("control register not at reset value");
	a_sel_locked: assert property (s_sel_write ##0
		cfg_reg.gate[`PFPC_GATE_BIT] |=> $stable(cfg_reg.sel))
		else $error("status select changed while locked");
	a_sel_taken: assert property (s_sel_write ##0
		!cfg_reg.gate[`PFPC_GATE_BIT] |=> cfg_reg.sel == $past(REQ_I.wdata))
		else $error("status select write lost");
	a_fd_ratio: assert property (s_pre_tick ##0 !dm |=>
		pre_cnt_reg == low_ratio($past(code)) - 6'h01)
		else $error("fixed divide ratio wrong");
	a_dm_swallow: assert property (s_pre_tick ##0 dm |=>
		pre_cnt_reg == low_ratio($past(code)) - 6'h01 +
		{5'h00, $past(a_cnt_next) != 6'h00})
		else $error("dual modulus ratio wrong");
	a_bypass_one: assert property (s_reload ##0
		cfg_reg.ctl[`PFPC_CTL_BYPASS] && !dm |=> b_cnt_reg == 13'h0001)
		else $error("bypass not dividing by one");
	a_coarse_norm: assert property (s_reload ##0
		!cfg_reg.ctl[`PFPC_CTL_BYPASS] && cfg_reg.coarse != 13'h0000
		|=> b_cnt_reg == $past(cfg_reg.coarse))
		else $error("coarse count not programmed value");
	a_pre_count: assert property (!hold && pre_cnt_reg != 6'h00
		|=> pre_cnt_reg == $past(pre_cnt_reg) - 6'h01)
		else $error("prescaler count skipped");
	a_err_flag: assert property (dm &&
		{7'h00, cfg_reg.swallow} > b_eff |=> CFG_ERR_O)
		else $error("swallow above coarse not flagged");
	a_status_gnd: assert property (cfg_reg.sel[7:2] == `PFPC_SEL_GND
		|=> !STATUS_O)
		else $error("status pin not grounded");
	a_ndiv_tick: assert property (s_reload |=> FB_DIV_O)
		else $error("feedback output missing");
endmodule
`default_nettype wire

//--- pkg/pfpc_regs.svh
// Register offsets, reset values and field positions of the feedback divider
// Assumes inclusion by the package and by the design file
`ifndef PFPC_REGS_SVH
`define PFPC_REGS_SVH

`define PFPC_AW          8
`define PFPC_OFS_SWALLOW 8'h13
`define PFPC_OFS_COARSE0 8'h14
`define PFPC_OFS_COARSE1 8'h15
`define PFPC_OFS_CTL     8'h16
`define PFPC_OFS_SEL     8'h17
`define PFPC_OFS_GATE    8'h1D

`define PFPC_RST_SWALLOW 6'h00
`define PFPC_RST_COARSE  13'h0003
`define PFPC_RST_CTL     8'h06
`define PFPC_RST_SEL     8'h00
`define PFPC_RST_GATE    8'h00

`define PFPC_CTL_RST_ALL 4
`define PFPC_CTL_RST_AB  5
`define PFPC_CTL_BYPASS  3
`define PFPC_GATE_BIT    7

`define PFPC_PRE_FD1     3'h0
`define PFPC_PRE_FD2     3'h1
`define PFPC_PRE_DM2     3'h2
`define PFPC_PRE_DM4     3'h3
`define PFPC_PRE_DM8     3'h4
`define PFPC_PRE_DM16    3'h5
`define PFPC_PRE_DM32    3'h6
`define PFPC_PRE_FD3     3'h7

`define PFPC_SEL_GND     6'h00
`define PFPC_SEL_NDIV    6'h01
`define PFPC_SEL_ADIV    6'h03
`define PFPC_SEL_PRE     6'h04

`endif

//--- pkg/pfpc_pkg.sv
// Types shared by the feedback prescaler configuration logic
// Assumes the register header defines the address width used here
`default_nettype none
`include "pfpc_regs.svh"
package pfpc_pkg;
	typedef struct packed {
		logic [5:0]  swallow;
		logic [12:0] coarse;
		logic [7:0]  ctl;
		logic [7:0]  sel;
		logic [7:0]  gate;
	} pfpc_cfg_t;

	typedef struct packed {
		logic                   wr;
		logic                   rd;
		logic [`PFPC_AW-1:0]    addr;
		logic [7:0]             wdata;
	} pfpc_req_t;
endpackage
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the feedback divider configuration block
// Assumes the design is reached only through its register request port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pfpc_pkg::*;
	logic        REF_CLK_I = 1'b0;
	logic        RESET_I   = 1'b1;
	pfpc_req_t   REQ_I     = '0;
	logic [7:0]  REG_RDATA_O;
	logic        PRESCALE_O;
	logic        FB_DIV_O;
	logic        STATUS_O;
	logic        CFG_ERR_O;
	int          fail_count = 0;
	int          checks     = 0;
	logic [31:0] seed       = 32'h7CEA8BA4;
	logic [7:0]  mdl [0:255];
	int          lowt [0:7] = '{1, 2, 2, 4, 8, 16, 32, 3};
	int          n, pc, a, b, ex, pb, e, fd, sc;
	logic        sig;

	always #25 REF_CLK_I = ~REF_CLK_I;

	pfpc_top DUT (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I), .REQ_I(REQ_I),
		.REG_RDATA_O(REG_RDATA_O), .PRESCALE_O(PRESCALE_O),
		.FB_DIV_O(FB_DIV_O), .STATUS_O(STATUS_O), .CFG_ERR_O(CFG_ERR_O));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [7:0] mask(input logic [7:0] ad);
		case (ad)
			8'h13: return 8'h3F;
			8'h15: return 8'h1F;
			8'h14, 8'h16, 8'h17, 8'h1D: return 8'hFF;
			default: return 8'h00;
		endcase
	endfunction

	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge REF_CLK_I) #1;
		REQ_I = '{1'b1, 1'b0, ad, d};
		@(posedge REF_CLK_I) #1;
		REQ_I = '0;
		if (!(ad == 8'h17 && mdl[8'h1D][7])) mdl[ad] = d & mask(ad);
	endtask

	task automatic rd(input logic [7:0] ad);
		@(posedge REF_CLK_I) #1;
		REQ_I = '{1'b0, 1'b1, ad, 8'h00};
		@(posedge REF_CLK_I) #1;
		REQ_I = '0;
		chk("rdata", {8'h00, REG_RDATA_O}, {8'h00, mdl[ad]});
	endtask

	// Cycles to the next feedback pulse, prescaler pulses counted meanwhile
	task automatic nextfb();
		n = 0;
		pc = 0;
		do begin
			@(posedge REF_CLK_I) #1;
			n++;
			pc += int'(PRESCALE_O === 1'b1);
		end while (FB_DIV_O !== 1'b1 && n < 600);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#(50 * 40000);
		fail_count++;
		summarize();
	end

	initial begin
		foreach (mdl[i]) mdl[i] = 8'h00;
		mdl[8'h14] = 8'h03;
		mdl[8'h16] = 8'h06;
		repeat (10) @(posedge REF_CLK_I);
		#1 RESET_I = 1'b0;
		// Reset values, unmapped place
		rd(8'h16);
		foreach (mdl[i]) if (i >= 8'h13 && i <= 8'h1D) rd(8'(i));
		wr(8'h20, 8'h5A);
		rd(8'h20);
		$display("test reset done");
		// Every prescaler code, fixed divide codes with and without coarse bypass
		for (int code = 0; code < 8; code++) begin
			for (int byp = 0; byp < 2; byp++) begin
				seed = lfsr(seed);
				b = 3 + int'(seed[3:2]);
				a = int'(seed[5:4]);
				wr(8'h13, 8'(a));
				wr(8'h14, 8'(b));
				wr(8'h15, 8'h00);
				fd = (code == 0 || code == 1 || code == 7) ? 1 : 0;
				wr(8'h16, 8'(16 + fd * byp * 8 + code));
				wr(8'h16, 8'(fd * byp * 8 + code));
				rd(8'h16);
				if (fd == 1) begin
					pb = byp ? 1 : b;
					ex = lowt[code] * pb;
				end else begin
					pb = b;
					ex = lowt[code] * b + a;
				end
				nextfb();
				nextfb();
				chk("fb_period", 16'(n), 16'(ex));
				chk("pre_count", 16'(pc), 16'(pb));
				chk("cfg_err", 16'(CFG_ERR_O), 16'h0000);
			end
		end
		$display("test divider done");
		// Status select, gated and open
		wr(8'h1D, 8'h80);
		wr(8'h17, 8'h04);
		rd(8'h17);
		wr(8'h1D, 8'h00);
		for (int k = 0; k < 3; k++) begin
			wr(8'h17, 8'(k * k * 4));
			rd(8'h17);
			e = 0;
			repeat (100) begin
				@(posedge REF_CLK_I) #1;
				sig = (k == 0) ? 1'b0 : (k == 1) ? FB_DIV_O : PRESCALE_O;
				e += int'(STATUS_O !== sig);
			end
			chk("status", 16'(e), 16'h0000);
		end
		$display("test status done");
		// Swallow-done pulse on the status pin, once per feedback period
		wr(8'h13, 8'h02);
		wr(8'h14, 8'h03);
		wr(8'h16, 8'h13);
		wr(8'h16, 8'h03);
		wr(8'h17, 8'h0C);
		rd(8'h17);
		nextfb();
		nextfb();
		chk("dm4_period", 16'(n), 16'(4 * 3 + 2));
		sc = 0;
		repeat (70) begin
			@(posedge REF_CLK_I) #1;
			sc += int'(STATUS_O === 1'b1);
		end
		chk("adiv_pulses", 16'(sc), 16'h0005);
		$display("test swallow pulse done");
		// Swallow above coarse in dual modulus
		wr(8'h13, 8'h05);
		wr(8'h14, 8'h03);
		wr(8'h16, 8'h06);
		repeat (3) @(posedge REF_CLK_I);
		#1 chk("cfg_err", 16'(CFG_ERR_O), 16'h0001);
		$display("test swallow done");
		// Reset in mid-run brings back the reset configuration
		@(posedge REF_CLK_I) #1;
		RESET_I = 1'b1;
		repeat (2) @(posedge REF_CLK_I);
		#1 RESET_I = 1'b0;
		foreach (mdl[i]) mdl[i] = 8'h00;
		mdl[8'h14] = 8'h03;
		mdl[8'h16] = 8'h06;
		foreach (mdl[i]) if (i >= 8'h13 && i <= 8'h1D) rd(8'(i));
		nextfb();
		nextfb();
		chk("reset_period", 16'(n), 16'(32 * 3));
		chk("cfg_err", 16'(CFG_ERR_O), 16'h0000);
		$display("test midrun reset done");
		summarize();
	end
endmodule
`default_nettype wire
